// [pkg/reset_init_pkg.sv]
/*
  Constants, register map and reset-type encoding for the reset initial-state block.
  Assumes an 8-bit register port and one 125 MHz system clock.
*/
// Overview of operation
// RQ1: Power-on clears timeout and power-down flags
// RQ2: Pin, low-voltage, USB resets keep both flags
// RQ3: Running watchdog reset sets timeout flag only
// RQ4: Idle watchdog reset sets both flags
// RQ5: Power-on disables interrupts, control zeroed
// RQ6: Reset clears watchdog, time base; watchdog restarts
// RQ7: Power-on stops all timer counters
// RQ8: Ports become inputs, all ones except idle-watchdog
// RQ9: Power-on points stack pointer at stack top
// RQ10: Values chosen by type; idle-watchdog keeps most
// RQ11: Idle watchdog reset zeroes counter and stack pointer
// RQ12: Low-voltage flag set by event, software clears
// RQ13: One reset-type indication selects value set
// RQ14: Undefined power-on bits are unchecked until written
package reset_init_pkg;

  typedef enum logic [2:0] {
    RT_NONE     = 3'h0,
    RT_POR      = 3'h1,
    RT_PIN      = 3'h2,
    RT_SUPPLY   = 3'h3,
    RT_USB      = 3'h4,
    RT_WDT_RUN  = 3'h5,
    RT_WDT_IDLE = 3'h6
  } reset_type_t;

  // Register indices on the plain port
  localparam logic [3:0] ADDR_STATUS     = 4'h0;
  localparam logic [3:0] ADDR_PC_LOW     = 4'h1;
  localparam logic [3:0] ADDR_SP         = 4'h2;
  localparam logic [3:0] ADDR_INT_CTRL   = 4'h3;
  localparam logic [3:0] ADDR_PORT_A     = 4'h4;
  localparam logic [3:0] ADDR_PORT_A_DIR = 4'h5;
  localparam logic [3:0] ADDR_RST_FLAG   = 4'h6;
  localparam logic [3:0] ADDR_TIMER_CTRL = 4'h7;
  localparam logic [3:0] ADDR_WDT        = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h9;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'ha;
  localparam logic [3:0] ADDR_RESET_TYPE = 4'hb;
  localparam logic [3:0] ADDR_TIMEBASE   = 4'hc;

  // Field positions
  localparam int STATUS_TO_BIT   = 5;
  localparam int STATUS_PD_BIT   = 4;
  localparam int SUPPLY_FLAG_BIT = 2;
  localparam int TIMER_RUN_BIT   = 0;
  localparam int IRQ_RESET_BIT   = 0;
  localparam int IRQ_WDT_BIT     = 1;
  localparam int IRQ_SUPPLY_BIT  = 2;

  // Values after reset
  localparam logic [7:0] STATUS_RST    = 8'h00;
  localparam logic [7:0] STATUS_WMASK  = 8'hcf;
  localparam logic [7:0] PC_LOW_RST    = 8'h00;
  localparam logic [2:0] SP_TOP        = 3'h7;
  localparam logic [2:0] SP_ZERO       = 3'h0;
  localparam logic [6:0] INT_CTRL_RST  = 7'h00;
  localparam logic [7:0] PORT_RST      = 8'hff;
  localparam logic [2:0] RST_FLAG_RST  = 3'h0;
  localparam logic [7:0] TIMER_RST     = 8'h00;
  localparam logic [2:0] IRQ_RST       = 3'h0;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [15:0] COUNT_ONE    = 16'h0001;
  localparam logic [15:0] WDT_LAST     = 16'hffff;

endpackage

// [rtl/reset_initial_state.sv]
/*
  Reset outcome logic: picks one reset type per event and loads the initial
  register values that the core and peripherals start from.
  Assumes detector pulses on i_clk, except the reset pin, which is asynchronous.
*/
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
module reset_initial_state (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_reset_pin,
  input  wire logic       i_low_voltage_reset,
  input  wire logic       i_usb_reset,
  input  wire logic       i_wdt_timeout,
  input  wire logic       i_idle_mode,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  output logic            o_reset_event,
  output logic      [2:0] o_reset_type,
  output logic            o_wdt_timeout_flag,
  output logic            o_power_down_flag,
  output logic      [7:0] o_program_counter_low,
  output logic      [2:0] o_stack_pointer,
  output logic      [6:0] o_interrupt_control_0,
  output logic      [7:0] o_port_a_data,
  output logic      [7:0] o_port_a_direction,
  output logic            o_timer_run
);

  reset_init_pkg::reset_type_t next_type;
  reset_init_pkg::reset_type_t reset_type;

  logic        pin_sync;
  logic        pin_prev;
  logic        pin_evt;
  logic        wdt_evt;
  logic        any_evt;
  logic        keep_state;
  logic [7:0]  status;
  logic [7:0]  program_counter_low;
  logic [2:0]  stack_pointer;
  logic [6:0]  interrupt_control_0;
  logic [7:0]  port_a_data;
  logic [7:0]  port_a_direction;
  logic [2:0]  reset_flag_register;
  logic [7:0]  timer_control;
  logic [15:0] watchdog_timer;
  logic [15:0] time_base;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic [2:0]  irq_set;
  logic        wr_status;
  logic        first_cycle;

  sync_two_ff #(
    .WIDTH (1)
  ) u_pin_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  (i_reset_pin),
    .o_sync   (pin_sync)
  );

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  assign pin_evt    = pin_sync & ~pin_prev;
  assign wdt_evt    = i_wdt_timeout | (watchdog_timer == reset_init_pkg::WDT_LAST);
  assign any_evt    = (next_type != reset_init_pkg::RT_NONE);
  assign keep_state = (next_type == reset_init_pkg::RT_WDT_IDLE);
  assign wr_status  = i_wr && (i_addr == reset_init_pkg::ADDR_STATUS);

  // Simultaneous sources collapse to one type, supply fault first
  always_comb begin
    next_type = reset_init_pkg::RT_NONE;
    if (i_low_voltage_reset) begin
      next_type = reset_init_pkg::RT_SUPPLY; // RQ13
    end else if (pin_evt) begin
      next_type = reset_init_pkg::RT_PIN;
    end else if (i_usb_reset) begin
      next_type = reset_init_pkg::RT_USB;
    end else if (wdt_evt) begin
      next_type = i_idle_mode ? reset_init_pkg::RT_WDT_IDLE : reset_init_pkg::RT_WDT_RUN;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reset_type    <= reset_init_pkg::RT_POR;
      o_reset_event <= 1'b1;
      first_cycle   <= 1'b1;
    end else begin
      first_cycle   <= 1'b0;
      o_reset_event <= any_evt; // RQ13
      if (any_evt) begin
        reset_type <= next_type;
      end
    end
  end

  // Status flags; other bits undefined at power-on, zero here
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status <= reset_init_pkg::STATUS_RST; // RQ1 RQ14
    end else begin
      if (wr_status) begin
        status <= (status & ~reset_init_pkg::STATUS_WMASK) |
                  (i_wdata & reset_init_pkg::STATUS_WMASK);
      end
      unique case (next_type)
        reset_init_pkg::RT_WDT_RUN: begin
          status[reset_init_pkg::STATUS_TO_BIT] <= 1'b1; // RQ3
        end
        reset_init_pkg::RT_WDT_IDLE: begin
          status[reset_init_pkg::STATUS_TO_BIT] <= 1'b1; // RQ4
          status[reset_init_pkg::STATUS_PD_BIT] <= 1'b1; // RQ10
        end
        default: begin // RQ2
          // Pin, supply and USB resets leave both flags alone
        end
      endcase
    end
  end

  // Program counter and stack pointer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      program_counter_low <= reset_init_pkg::PC_LOW_RST;
      stack_pointer       <= reset_init_pkg::SP_TOP; // RQ9
    end else if (any_evt) begin
      program_counter_low <= reset_init_pkg::PC_LOW_RST; // RQ10
      stack_pointer       <= keep_state ? reset_init_pkg::SP_ZERO : reset_init_pkg::SP_TOP; // RQ11
    end
  end

  // Interrupt control, ports and timers: idle watchdog keeps them
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      interrupt_control_0 <= reset_init_pkg::INT_CTRL_RST; // RQ5
      port_a_data         <= reset_init_pkg::PORT_RST; // RQ8
      port_a_direction    <= reset_init_pkg::PORT_RST;
      timer_control       <= reset_init_pkg::TIMER_RST; // RQ7
    end else if (any_evt) begin
      if (!keep_state) begin
        interrupt_control_0 <= reset_init_pkg::INT_CTRL_RST; // RQ10
        port_a_data         <= reset_init_pkg::PORT_RST; // RQ8
        port_a_direction    <= reset_init_pkg::PORT_RST;
        timer_control       <= reset_init_pkg::TIMER_RST; // RQ7
      end
    end else if (i_wr) begin
      unique case (i_addr)
        reset_init_pkg::ADDR_INT_CTRL:   interrupt_control_0 <= i_wdata[6:0];
        reset_init_pkg::ADDR_PORT_A:     port_a_data         <= i_wdata;
        reset_init_pkg::ADDR_PORT_A_DIR: port_a_direction    <= i_wdata;
        reset_init_pkg::ADDR_TIMER_CTRL: timer_control       <= i_wdata;
        default: begin
        end
      endcase
    end
  end

  // Watchdog and time base restart on every reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      watchdog_timer <= reset_init_pkg::COUNT_RST;
      time_base      <= reset_init_pkg::COUNT_RST;
    end else if (any_evt) begin
      watchdog_timer <= reset_init_pkg::COUNT_RST; // RQ6
      time_base      <= reset_init_pkg::COUNT_RST;
    end else begin
      time_base <= time_base + reset_init_pkg::COUNT_ONE;
      if (i_wr && (i_addr == reset_init_pkg::ADDR_WDT)) begin
        watchdog_timer <= reset_init_pkg::COUNT_RST;
      end else begin
        watchdog_timer <= watchdog_timer + reset_init_pkg::COUNT_ONE;
      end
    end
  end

  // Low-voltage flag: an event beats a clearing write in the same cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reset_flag_register <= reset_init_pkg::RST_FLAG_RST;
    end else if (next_type == reset_init_pkg::RT_SUPPLY) begin
      reset_flag_register[reset_init_pkg::SUPPLY_FLAG_BIT] <= 1'b1; // RQ12
    end else if (i_wr && (i_addr == reset_init_pkg::ADDR_RST_FLAG)) begin
      reset_flag_register <= reset_flag_register & i_wdata[2:0]; // RQ12
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[reset_init_pkg::IRQ_RESET_BIT] = any_evt;
    irq_set[reset_init_pkg::IRQ_WDT_BIT]   = wdt_evt;
    irq_set[reset_init_pkg::IRQ_SUPPLY_BIT] = (next_type == reset_init_pkg::RT_SUPPLY);
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_status <= reset_init_pkg::IRQ_RST;
      irq_mask   <= reset_init_pkg::IRQ_RST;
      o_irq      <= 1'b0;
    end else begin
      if (i_wr && (i_addr == reset_init_pkg::ADDR_IRQ_STATUS)) begin
        irq_status <= (irq_status & ~i_wdata[2:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      if (i_wr && (i_addr == reset_init_pkg::ADDR_IRQ_MASK)) begin
        irq_mask <= i_wdata[2:0];
      end
      o_irq <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        reset_init_pkg::ADDR_STATUS:     o_rdata <= status;
        reset_init_pkg::ADDR_PC_LOW:     o_rdata <= program_counter_low;
        reset_init_pkg::ADDR_SP:         o_rdata <= {5'h00, stack_pointer};
        reset_init_pkg::ADDR_INT_CTRL:   o_rdata <= {1'b0, interrupt_control_0};
        reset_init_pkg::ADDR_PORT_A:     o_rdata <= port_a_data;
        reset_init_pkg::ADDR_PORT_A_DIR: o_rdata <= port_a_direction;
        reset_init_pkg::ADDR_RST_FLAG:   o_rdata <= {5'h00, reset_flag_register};
        reset_init_pkg::ADDR_TIMER_CTRL: o_rdata <= timer_control;
        reset_init_pkg::ADDR_WDT:        o_rdata <= watchdog_timer[15:8];
        reset_init_pkg::ADDR_IRQ_STATUS: o_rdata <= {5'h00, irq_status};
        reset_init_pkg::ADDR_IRQ_MASK:   o_rdata <= {5'h00, irq_mask};
        reset_init_pkg::ADDR_RESET_TYPE: o_rdata <= {5'h00, reset_type};
        reset_init_pkg::ADDR_TIMEBASE:   o_rdata <= time_base[15:8];
        default:                         o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  assign o_reset_type          = reset_type;
  assign o_wdt_timeout_flag    = status[reset_init_pkg::STATUS_TO_BIT];
  assign o_power_down_flag     = status[reset_init_pkg::STATUS_PD_BIT];
  assign o_program_counter_low = program_counter_low;
  assign o_stack_pointer       = stack_pointer;
  assign o_interrupt_control_0 = interrupt_control_0;
  assign o_port_a_data         = port_a_data;
  assign o_port_a_direction    = port_a_direction;
  assign o_timer_run           = timer_control[reset_init_pkg::TIMER_RUN_BIT];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_ordinary_reset;
    any_evt && !keep_state;
  endsequence

  sequence s_idle_wdt_reset;
    next_type == reset_init_pkg::RT_WDT_IDLE;
  endsequence

  sequence s_counters_cleared;
    watchdog_timer == reset_init_pkg::COUNT_RST && time_base == reset_init_pkg::COUNT_RST;
  endsequence

  sequence s_counting_again;
    watchdog_timer == reset_init_pkg::COUNT_ONE || o_reset_event;
  endsequence

  property p_por_flags;
    first_cycle |-> !o_wdt_timeout_flag && !o_power_down_flag && o_reset_event;
  endproperty
  a_por_flags: assert property (p_por_flags) // RQ1
    else $error("flags not clear after power-on");

  property p_keep_flags;
    (next_type == reset_init_pkg::RT_PIN || next_type == reset_init_pkg::RT_SUPPLY ||
     next_type == reset_init_pkg::RT_USB)
      |=> $stable(o_wdt_timeout_flag) && $stable(o_power_down_flag);
  endproperty
  a_keep_flags: assert property (p_keep_flags) // RQ2
    else $error("pin, supply or USB reset changed a flag");

  property p_wdt_run;
    next_type == reset_init_pkg::RT_WDT_RUN
      |=> o_wdt_timeout_flag && $stable(o_power_down_flag) &&
          o_reset_type == reset_init_pkg::RT_WDT_RUN;
  endproperty
  a_wdt_run: assert property (p_wdt_run) // RQ3
    else $error("running watchdog reset flags wrong");

  property p_wdt_idle;
    s_idle_wdt_reset |=> o_wdt_timeout_flag && o_power_down_flag &&
                         o_program_counter_low == reset_init_pkg::PC_LOW_RST &&
                         o_stack_pointer == reset_init_pkg::SP_ZERO;
  endproperty
  a_wdt_idle: assert property (p_wdt_idle) // RQ4
    else $error("idle watchdog reset outcome wrong");

  property p_idle_keeps;
    s_idle_wdt_reset |=> $stable(o_port_a_data) && $stable(o_port_a_direction) &&
                         $stable(o_interrupt_control_0) && $stable(o_timer_run);
  endproperty
  a_idle_keeps: assert property (p_idle_keeps) // RQ10
    else $error("idle watchdog reset disturbed kept state");

  property p_intc_clear;
    s_ordinary_reset |=> o_interrupt_control_0 == reset_init_pkg::INT_CTRL_RST;
  endproperty
  a_intc_clear: assert property (p_intc_clear) // RQ5
    else $error("interrupt control not cleared");

  property p_wdt_restart;
    any_evt |=> s_counters_cleared ##1 s_counting_again;
  endproperty
  a_wdt_restart: assert property (p_wdt_restart) // RQ6
    else $error("watchdog did not restart from zero");

  property p_timer_off;
    s_ordinary_reset |=> !o_timer_run;
  endproperty
  a_timer_off: assert property (p_timer_off) // RQ7
    else $error("timer still running after reset");

  property p_ports_input;
    s_ordinary_reset |=> o_port_a_data == reset_init_pkg::PORT_RST &&
                         o_port_a_direction == reset_init_pkg::PORT_RST;
  endproperty
  a_ports_input: assert property (p_ports_input) // RQ8
    else $error("port A not reset to inputs");

  property p_sp_top;
    s_ordinary_reset |=> o_stack_pointer == reset_init_pkg::SP_TOP;
  endproperty
  a_sp_top: assert property (p_sp_top) // RQ9
    else $error("stack pointer not at top");

  property p_supply_flag;
    next_type == reset_init_pkg::RT_SUPPLY
      |=> reset_flag_register[reset_init_pkg::SUPPLY_FLAG_BIT] && o_reset_event;
  endproperty
  a_supply_flag: assert property (p_supply_flag) // RQ12
    else $error("low-voltage flag not set");

  property p_supply_flag_hold;
    reset_flag_register[reset_init_pkg::SUPPLY_FLAG_BIT] &&
    !(i_wr && i_addr == reset_init_pkg::ADDR_RST_FLAG)
      |=> reset_flag_register[reset_init_pkg::SUPPLY_FLAG_BIT];
  endproperty
  a_supply_flag_hold: assert property (p_supply_flag_hold) // RQ12
    else $error("low-voltage flag lost without a write");

  property p_one_type;
    any_evt |=> o_reset_event && o_reset_type == $past(next_type);
  endproperty
  a_one_type: assert property (p_one_type) // RQ13
    else $error("reset event without a type");

endmodule

// [rtl/sync_two_ff.sv]
/*
  Two flip-flop synchroniser for levels from outside the clock domain.
  Assumes the input is slow compared with the 125 MHz clock.
*/
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// [verif/core_model.sv]
/*
  Behavioural core: goes idle on a sleep request, wakes on any reset event.
  Assumes the block's clock and power-on reset.
*/
`timescale 1ns/1ps
module core_model (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_sleep_req,
  input  wire logic i_reset_event,
  output logic      o_idle_mode
);
  // Any reset restarts the core, so idle never outlives an event
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_idle_mode <= 1'b0;
    end else if (i_reset_event) begin
      o_idle_mode <= 1'b0;
    end else if (i_sleep_req) begin
      o_idle_mode <= 1'b1;
    end
  end
endmodule

// [verif/reset_initial_state_tb_top.sv]
/*
  Self-checking bench for the reset initial-state block.
  Assumes the core model beside it and one 125 MHz clock.
*/
`timescale 1ns/1ps
module reset_initial_state_tb_top;
  logic       i_clk = 1'b0;
  logic       i_arst_n = 1'b0;
  logic       i_reset_pin = 1'b0;
  logic       i_low_voltage_reset = 1'b0;
  logic       i_usb_reset = 1'b0;
  logic       i_wdt_timeout = 1'b0;
  logic       i_idle_mode;
  logic       sleep_req = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic       o_irq;
  logic       o_reset_event;
  logic [2:0] o_reset_type;
  logic       o_wdt_timeout_flag;
  logic       o_power_down_flag;
  logic [7:0] o_program_counter_low;
  logic [2:0] o_stack_pointer;
  logic [6:0] o_interrupt_control_0;
  logic [7:0] o_port_a_data;
  logic [7:0] o_port_a_direction;
  logic       o_timer_run;
  int         err_total = 0;
  int         n_compared = 0;
  int         cycles = 0;

  always #4 i_clk = ~i_clk;

  reset_initial_state u_reset_initial_state (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_reset_pin(i_reset_pin),
    .i_low_voltage_reset(i_low_voltage_reset), .i_usb_reset(i_usb_reset),
    .i_wdt_timeout(i_wdt_timeout), .i_idle_mode(i_idle_mode), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_reset_event(o_reset_event), .o_reset_type(o_reset_type),
    .o_wdt_timeout_flag(o_wdt_timeout_flag), .o_power_down_flag(o_power_down_flag),
    .o_program_counter_low(o_program_counter_low), .o_stack_pointer(o_stack_pointer),
    .o_interrupt_control_0(o_interrupt_control_0), .o_port_a_data(o_port_a_data),
    .o_port_a_direction(o_port_a_direction), .o_timer_run(o_timer_run));

  core_model u_core_model (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_sleep_req(sleep_req),
    .i_reset_event(o_reset_event), .o_idle_mode(i_idle_mode));

  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(what, exp, o_rdata);
  endtask

  // 2 pin, 3 low voltage, 4 usb, else watchdog
  task automatic fire(input int src);
    int n;
    @(posedge i_clk);
    case (src)
      2: i_reset_pin <= 1'b1;
      3: i_low_voltage_reset <= 1'b1;
      4: i_usb_reset <= 1'b1;
      default: i_wdt_timeout <= 1'b1;
    endcase
    @(posedge i_clk);
    i_low_voltage_reset <= 1'b0;
    i_usb_reset <= 1'b0;
    i_wdt_timeout <= 1'b0;
    n = 0;
    #1;
    while (o_reset_event !== 1'b1 && n < 8) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("event_lag", (src == 2) ? 8'h02 : 8'h00, 8'(n));
    chk("reset_event", 8'h01, {7'h0, o_reset_event});
    @(posedge i_clk);
    i_reset_pin <= 1'b0;
    #1;
    chk("reset_event_end", 8'h00, {7'h0, o_reset_event});
  endtask

  task automatic check_state(input logic [2:0] rt, input logic to, input logic pd,
                             input logic [2:0] sp, input logic keep);
    chk("reset_type", {5'h0, rt}, {5'h0, o_reset_type});
    chk("wdt_timeout_flag", {7'h0, to}, {7'h0, o_wdt_timeout_flag});
    chk("power_down_flag", {7'h0, pd}, {7'h0, o_power_down_flag});
    chk("program_counter_low", 8'h00, o_program_counter_low);
    chk("stack_pointer", {5'h0, sp}, {5'h0, o_stack_pointer});
    chk("interrupt_control_0", keep ? 8'h55 : 8'h00, {1'b0, o_interrupt_control_0});
    chk("port_a_data", keep ? 8'h3c : 8'hff, o_port_a_data);
    chk("port_a_direction", keep ? 8'ha5 : 8'hff, o_port_a_direction);
    chk("timer_run", {7'h0, keep}, {7'h0, o_timer_run});
    rd(reset_init_pkg::ADDR_WDT, 8'h00, "watchdog_timer");
    rd(reset_init_pkg::ADDR_TIMEBASE, 8'h00, "timebase");
  endtask

  task automatic set_regs();
    wr(reset_init_pkg::ADDR_INT_CTRL, 8'h55);
    wr(reset_init_pkg::ADDR_PORT_A, 8'h3c);
    wr(reset_init_pkg::ADDR_PORT_A_DIR, 8'ha5);
    wr(reset_init_pkg::ADDR_TIMER_CTRL, 8'h01);
    rd(reset_init_pkg::ADDR_PORT_A, 8'h3c, "port_a_readback");
  endtask

  task automatic t_wdt_run();
    set_regs();
    fire(5);
    check_state(3'h5, 1'b1, 1'b0, 3'h7, 1'b0);
  endtask

  task automatic t_wdt_idle();
    set_regs();
    @(posedge i_clk);
    sleep_req <= 1'b1;
    @(posedge i_clk);
    sleep_req <= 1'b0;
    fire(5);
    check_state(3'h6, 1'b1, 1'b1, 3'h0, 1'b1);
  endtask

  // Flags stand at 1 here, so a clearing slip shows
  task automatic t_other();
    for (int s = 2; s <= 4; s++) begin
      set_regs();
      fire(s);
      check_state(3'(s), 1'b1, 1'b1, 3'h7, 1'b0);
    end
    rd(reset_init_pkg::ADDR_RST_FLAG, 8'h04, "low_voltage_flag");
    wr(reset_init_pkg::ADDR_RST_FLAG, 8'h00);
    rd(reset_init_pkg::ADDR_RST_FLAG, 8'h00, "low_voltage_flag_clr");
  endtask

  task automatic t_irq();
    wr(reset_init_pkg::ADDR_IRQ_STATUS, 8'h07);
    wr(reset_init_pkg::ADDR_IRQ_MASK, 8'h00);
    fire(5);
    rd(reset_init_pkg::ADDR_IRQ_STATUS, 8'h03, "irq_status");
    chk("irq_masked", 8'h00, {7'h0, o_irq});
    wr(reset_init_pkg::ADDR_IRQ_MASK, 8'h02);
    repeat (2) @(posedge i_clk);
    #1;
    chk("irq_raised", 8'h01, {7'h0, o_irq});
    wr(reset_init_pkg::ADDR_IRQ_STATUS, 8'h02);
    repeat (2) @(posedge i_clk);
    #1;
    chk("irq_cleared", 8'h00, {7'h0, o_irq});
  endtask

  task automatic t_bus();
    rd(4'hd, 8'h00, "unmapped");
    wr(reset_init_pkg::ADDR_PC_LOW, 8'h12);
    rd(reset_init_pkg::ADDR_PC_LOW, 8'h00, "pc_low_read_only");
    wr(reset_init_pkg::ADDR_STATUS, 8'h0a);
    rd(reset_init_pkg::ADDR_STATUS, 8'h3a, "status");
  endtask

  // Second power-on in mid-run, after flags were set
  task automatic t_por2();
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    check_state(3'h1, 1'b0, 1'b0, 3'h7, 1'b0);
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    check_state(3'h1, 1'b0, 1'b0, 3'h7, 1'b0);
    t_wdt_run();
    t_wdt_idle();
    t_other();
    t_irq();
    t_bus();
    t_por2();
    print_verdict();
  end
endmodule
